// [hw/adcsr_pkg.sv]
// package of register map constants for the converter identity and status register bank
package adcsr_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [5:0] IDX_ID = 6'h00;
	localparam logic [5:0] IDX_STATUS = 6'h01;
	localparam logic [5:0] IDX_MODE = 6'h02;
	localparam logic [5:0] IDX_CH3_PHASE = 6'h18;
	localparam logic [5:0] IDX_CH3_OCAL_HI = 6'h19;
	localparam logic [5:0] IDX_CH3_OCAL_LO = 6'h1A;
	localparam logic [5:0] IDX_CH3_GCAL_HI = 6'h1B;
	localparam logic [5:0] IDX_CH3_GCAL_LO = 6'h1C;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
	localparam logic [5:0] IDX_CRC = 6'h3E;
	localparam logic [5:0] IDX_RSVD = 6'h3F;
	localparam logic [1:0] ALIGN_OK = 2'h0;

	// identity word fields
	localparam logic [3:0] CHANNEL_TOTAL = 4'h4;
	// arbitrary part code, not a real one
	localparam logic [3:0] ID_UPPER_DEFAULT = 4'hA;
	// arbitrary version byte, not a real one
	localparam logic [7:0] ID_LOW_DEFAULT = 8'h5C;

	// status word bit positions
	localparam int ST_LOCK = 15;
	localparam int ST_RESYNC = 14;
	localparam int ST_REGMAP = 13;
	localparam int ST_CRC_ERR = 12;
	localparam int ST_CRC_TYPE = 11;
	localparam int ST_RESET = 10;
	localparam int ST_WLEN_HI = 9;
	localparam int ST_WLEN_LO = 8;
	localparam logic [3:0] ST_RSVD_BITS = 4'h0;
	localparam logic [15:0] STATUS_RESET = 16'h0500;

	// mode word fields and reset values
	localparam int MODE_REG_CRC_EN = 13;
	localparam int MODE_CRC_TYPE = 11;
	localparam int MODE_RESET = 10;
	localparam int MODE_WLEN_HI = 9;
	localparam int MODE_WLEN_LO = 8;
	localparam logic [15:0] MODE_RESET_VAL = 16'h0510;
	localparam logic [15:0] MODE_WMASK = 16'h3F1F;

	// channel 3 calibration reset values and masks
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] GAIN_RESET_VAL = 16'h8000;
	localparam logic [15:0] LOW_WMASK = 16'hFF00;
	localparam logic [15:0] FULL_WMASK = 16'hFFFF;

	// interrupt status bit positions
	localparam int IRQ_W = 4;
	localparam int IRQ_RESYNC = 0;
	localparam int IRQ_REGMAP = 1;
	localparam int IRQ_CRC = 2;
	localparam int IRQ_DATA = 3;
	localparam logic [3:0] IRQ_NONE = 4'h0;
endpackage

// [hw/adcsr_sync.sv]
// two flip-flop synchroniser for levels arriving from outside the clock domain
module adcsr_sync #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic [W-1:0] d_async,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} adcsr_sync_t;

	adcsr_sync_t st;
	adcsr_sync_t next_st;

	// first stage feeds only the second stage
	always_comb
	begin
		next_st = st;
		if (ce)
		begin
			next_st.s1 = d_async;
			next_st.s2 = st.s1;
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign q = st.s2;
endmodule

// [hw/adcsr_regs.sv]
// identity, status, mode and channel 3 register bank with apb slave and interrupt
module adcsr_regs #(
	parameter logic [3:0] ID_UPPER = adcsr_pkg::ID_UPPER_DEFAULT,
	parameter logic [7:0] ID_LOW = adcsr_pkg::ID_LOW_DEFAULT,
	parameter int NCHAN = 4
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic link_lock,
	input wire logic resync_pulse,
	input wire logic [NCHAN-1:0] new_sample,
	input wire logic [15:0] register_map_checksum_value,
	input wire logic link_sclk,
	input wire logic link_crc_fail,
	output logic irq
);
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] ch3_phase;
		logic [15:0] ocal_hi;
		logic [15:0] ocal_lo;
		logic [15:0] gcal_hi;
		logic [15:0] gcal_lo;
		logic resync_flag;
		logic regmap_flag;
		logic crc_err_flag;
		logic [15:0] crc_ref;
		logic sclk_prev;
		logic [NCHAN-1:0] data_prev;
		logic [adcsr_pkg::IRQ_W-1:0] irq_status;
		logic [adcsr_pkg::IRQ_W-1:0] irq_mask;
		logic rd_valid;
		logic [31:0] prdata;
		logic slverr;
	} adcsr_state_t;

	adcsr_state_t st;
	adcsr_state_t next_st;
	logic [1:0] link_sync;
	logic sclk_s;
	logic crc_fail_s;
	logic [5:0] idx;
	logic [15:0] status_word;
	logic [15:0] wmask;
	logic access;
	logic wr_done;
	logic rd_done;
	logic sclk_rise;

	// serial clock and checksum-fail level come from the link side
	adcsr_sync #(
		.W(2)
	) u_link_sync (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.d_async({link_sclk, link_crc_fail}),
		.q(link_sync)
	);

	assign sclk_s = link_sync[1];
	assign crc_fail_s = link_sync[0];
	assign sclk_rise = sclk_s && !st.sclk_prev;

	// misaligned addresses land on the reserved word, so a write there changes nothing
	assign idx = (paddr[1:0] == adcsr_pkg::ALIGN_OK) ? paddr[7:2] : adcsr_pkg::IDX_RSVD;
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign pready = penable && st.rd_valid && ce;
	assign access = psel && penable && pready;
	assign wr_done = access && pwrite;
	assign rd_done = access && !pwrite;
	assign prdata = st.prdata;
	assign pslverr = access && st.slverr;
	assign irq = |(st.irq_status & st.irq_mask);

	// live status word; mode fields are mirrored, not stored twice
	// status fields
	always_comb
	begin
		status_word = {link_lock, st.resync_flag, st.regmap_flag, st.crc_err_flag,
			st.mode[adcsr_pkg::MODE_CRC_TYPE], st.mode[adcsr_pkg::MODE_RESET],
			st.mode[adcsr_pkg::MODE_WLEN_HI:adcsr_pkg::MODE_WLEN_LO],
			adcsr_pkg::ST_RSVD_BITS, new_sample};
	end

	// read decode: hit flag and word, shared by capture and error answer
	function automatic logic [16:0] read_word(input logic [5:0] i, input adcsr_state_t s,
		input logic [15:0] stw, input logic [15:0] crc);
		logic [16:0] r;
		r = {1'b1, adcsr_pkg::ZERO16};
		unique case (i)
			adcsr_pkg::IDX_ID: r[15:0] = {ID_UPPER, adcsr_pkg::CHANNEL_TOTAL, ID_LOW};
			adcsr_pkg::IDX_STATUS: r[15:0] = stw;
			adcsr_pkg::IDX_MODE: r[15:0] = s.mode;
			adcsr_pkg::IDX_CH3_PHASE: r[15:0] = s.ch3_phase;
			adcsr_pkg::IDX_CH3_OCAL_HI: r[15:0] = s.ocal_hi;
			adcsr_pkg::IDX_CH3_OCAL_LO: r[15:0] = s.ocal_lo;
			adcsr_pkg::IDX_CH3_GCAL_HI: r[15:0] = s.gcal_hi;
			adcsr_pkg::IDX_CH3_GCAL_LO: r[15:0] = s.gcal_lo;
			adcsr_pkg::IDX_IRQ_STATUS: r[15:0] = {12'h000, s.irq_status};
			adcsr_pkg::IDX_IRQ_MASK: r[15:0] = {12'h000, s.irq_mask};
			adcsr_pkg::IDX_CRC: r[15:0] = crc;
			adcsr_pkg::IDX_RSVD: r[15:0] = adcsr_pkg::ZERO16;
			default: r = {1'b0, adcsr_pkg::ZERO16};
		endcase
		return r;
	endfunction

	// next-state logic; clears from reads come first so hardware sets win
	always_comb
	begin
		logic [16:0] rw;
		logic [adcsr_pkg::IRQ_W-1:0] ev;
		logic crc_changed;
		rw = read_word(idx, st, status_word, register_map_checksum_value);
		ev = adcsr_pkg::IRQ_NONE;
		crc_changed = register_map_checksum_value != st.crc_ref;
		next_st = st;
		if (ce)
		begin
			// capture read data in the setup cycle so prdata comes from a flop
			if (psel && !st.rd_valid)
			begin
				next_st.rd_valid = 1'b1;
				next_st.prdata = {adcsr_pkg::ZERO16, rw[15:0]};
				// a misaligned address answers with an error as well
				next_st.slverr = !rw[16] || paddr[1:0] != adcsr_pkg::ALIGN_OK;
			end
			if (access)
				next_st.rd_valid = 1'b0;
			// reading status clears its sticky event flags
			if (rd_done && idx == adcsr_pkg::IDX_STATUS)
			begin
				next_st.resync_flag = 1'b0;
				next_st.regmap_flag = 1'b0;
				next_st.crc_err_flag = 1'b0;
			end
			if (rd_done && idx == adcsr_pkg::IDX_IRQ_STATUS)
				next_st.irq_status = adcsr_pkg::IRQ_NONE;
			// identity, status and checksum words have no write path
			if (wr_done)
			begin
				unique case (idx)
					adcsr_pkg::IDX_MODE:
					begin
						next_st.mode = (st.mode & ~(wmask & adcsr_pkg::MODE_WMASK))
							| (pwdata[15:0] & wmask & adcsr_pkg::MODE_WMASK);
						// reset flag only clears, software cannot set it
						next_st.mode[adcsr_pkg::MODE_RESET] = st.mode[adcsr_pkg::MODE_RESET]
							&& (pwdata[adcsr_pkg::MODE_RESET] || !pstrb[1]);
					end
					adcsr_pkg::IDX_CH3_PHASE:
						next_st.ch3_phase = (st.ch3_phase & ~wmask) | (pwdata[15:0] & wmask);
					adcsr_pkg::IDX_CH3_OCAL_HI:
						next_st.ocal_hi = (st.ocal_hi & ~wmask) | (pwdata[15:0] & wmask);
					adcsr_pkg::IDX_CH3_OCAL_LO:
						next_st.ocal_lo = (st.ocal_lo & ~(wmask & adcsr_pkg::LOW_WMASK))
							| (pwdata[15:0] & wmask & adcsr_pkg::LOW_WMASK);
					adcsr_pkg::IDX_CH3_GCAL_HI:
						next_st.gcal_hi = (st.gcal_hi & ~wmask) | (pwdata[15:0] & wmask);
					adcsr_pkg::IDX_CH3_GCAL_LO:
						next_st.gcal_lo = (st.gcal_lo & ~(wmask & adcsr_pkg::LOW_WMASK))
							| (pwdata[15:0] & wmask & adcsr_pkg::LOW_WMASK);
					adcsr_pkg::IDX_IRQ_MASK:
						next_st.irq_mask = (st.irq_mask & ~wmask[adcsr_pkg::IRQ_W-1:0])
							| (pwdata[adcsr_pkg::IRQ_W-1:0] & wmask[adcsr_pkg::IRQ_W-1:0]);
					default:
					begin
					end
				endcase
			end
			if (resync_pulse)
			begin
				next_st.resync_flag = 1'b1;
				ev[adcsr_pkg::IRQ_RESYNC] = 1'b1;
			end
			// supervision only while enabled, flag cleared otherwise; reference tracks in both cases
			if (st.mode[adcsr_pkg::MODE_REG_CRC_EN])
			begin
				if (crc_changed)
				begin
					next_st.regmap_flag = 1'b1;
					ev[adcsr_pkg::IRQ_REGMAP] = 1'b1;
				end
			end
			else
				next_st.regmap_flag = 1'b0;
			next_st.crc_ref = register_map_checksum_value;
			// checksum failure sampled on the serial clock rising edge
			next_st.sclk_prev = sclk_s;
			if (sclk_rise && crc_fail_s)
			begin
				next_st.crc_err_flag = 1'b1;
				ev[adcsr_pkg::IRQ_CRC] = 1'b1;
			end
			// any channel gaining new data raises the data event
			next_st.data_prev = new_sample;
			if (|(new_sample & ~st.data_prev))
				ev[adcsr_pkg::IRQ_DATA] = 1'b1;
			next_st.irq_status = next_st.irq_status | ev;
		end
	end

	// state register; reset leaves the reset flag set
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.mode <= adcsr_pkg::MODE_RESET_VAL;
			st.gcal_hi <= adcsr_pkg::GAIN_RESET_VAL;
		end
		else
			st <= next_st;
	end

	// checks on the register bank behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// helpers: a completed identity read, and a status capture in the setup cycle
	logic id_read;
	logic st_cap;
	assign id_read = rd_done && idx == adcsr_pkg::IDX_ID;
	assign st_cap = ce && psel && !st.rd_valid && idx == adcsr_pkg::IDX_STATUS;

	id_upper_a: assert property (id_read |-> prdata[15:12] == ID_UPPER)
		else $error("identity upper nibble wrong");
	chan_total_a: assert property (id_read |-> prdata[11:8] == adcsr_pkg::CHANNEL_TOTAL)
		else $error("channel total field wrong");
	reset_word_a: assert property ($past(!resetn) |-> status_word[15:4]
		== {link_lock, adcsr_pkg::STATUS_RESET[14:4]})
		else $error("status not at reset value");
	lock_read_a: assert property (st_cap |=> prdata[adcsr_pkg::ST_LOCK] == $past(link_lock))
		else $error("lock bit not returned");
	resync_set_a: assert property (ce && resync_pulse |=> st.resync_flag)
		else $error("resync flag not set");
	regmap_set_a: assert property (ce && st.mode[adcsr_pkg::MODE_REG_CRC_EN]
		&& register_map_checksum_value != st.crc_ref |=> st.regmap_flag)
		else $error("checksum change missed");
	regmap_off_a: assert property (ce && !st.mode[adcsr_pkg::MODE_REG_CRC_EN]
		|=> !st.regmap_flag)
		else $error("supervision ran while disabled");
	crc_err_a: assert property (ce && sclk_rise && crc_fail_s |=> st.crc_err_flag)
		else $error("input checksum error missed");
	crc_kind_a: assert property (st_cap |=> prdata[adcsr_pkg::ST_CRC_TYPE]
		== $past(st.mode[adcsr_pkg::MODE_CRC_TYPE]))
		else $error("checksum kind not mirrored");
	reset_hold_a: assert property (!st.mode[adcsr_pkg::MODE_RESET]
		|=> !st.mode[adcsr_pkg::MODE_RESET])
		else $error("reset flag set by software");
	wlen_read_a: assert property (st_cap
		|=> prdata[adcsr_pkg::ST_WLEN_HI:adcsr_pkg::ST_WLEN_LO]
		== $past(st.mode[adcsr_pkg::MODE_WLEN_HI:adcsr_pkg::MODE_WLEN_LO]))
		else $error("word length not mirrored");
	reset_clear_a: assert property (wr_done && idx == adcsr_pkg::IDX_MODE && pstrb[1]
		&& !pwdata[adcsr_pkg::MODE_RESET] |=> !st.mode[adcsr_pkg::MODE_RESET])
		else $error("reset flag not cleared");
	new_data_a: assert property (st_cap |=> prdata[NCHAN-1:0] == $past(new_sample))
		else $error("new data bits wrong");
	// sticky clear by a status read, and no write path behind the status word
	resync_clear_a: assert property (rd_done && idx == adcsr_pkg::IDX_STATUS
		&& !resync_pulse |=> !st.resync_flag)
		else $error("resync flag not cleared by read");
	status_ro_a: assert property (wr_done && idx == adcsr_pkg::IDX_STATUS
		|=> st.mode == $past(st.mode))
		else $error("status write changed the mode word");

	status_read_c: cover property (rd_done && idx == adcsr_pkg::IDX_STATUS);
	mode_write_c: cover property (wr_done && idx == adcsr_pkg::IDX_MODE);
	irq_raise_c: cover property (!irq ##1 irq);
	crc_err_c: cover property (ce && sclk_rise && crc_fail_s);
endmodule

// [testbench/adcsr_link_model.sv]
// serial link stand-in that clocks frames and flags input checksum failures
module adcsr_link_model (
	output logic link_sclk,
	output logic link_crc_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	// link clock parked low between frames
	initial
	begin
		link_sclk = 1'b0;
		link_crc_fail = 1'b0;
	end
	// one frame of four link clocks at 160 ns; bad marks a checksum mismatch
	// input checksum error
	task automatic frame(input logic bad);
		#3 link_crc_fail = bad;
		repeat (4)
		begin
			#80 link_sclk = 1'b1;
			#80 link_sclk = 1'b0;
		end
		// a released line must not look like a held value, so it flips
		#80 link_crc_fail = ~bad;
	endtask
endmodule

// [testbench/adc_status_identity_regs_bench.sv]
// self-checking bench for the identity and status register bank
module adc_status_identity_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_ID = {adcsr_pkg::IDX_ID, 2'b00};
	localparam logic [7:0] A_ST = {adcsr_pkg::IDX_STATUS, 2'b00};
	localparam logic [7:0] A_MODE = {adcsr_pkg::IDX_MODE, 2'b00};
	localparam logic [7:0] A_IRQ = {adcsr_pkg::IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] A_MASK = {adcsr_pkg::IDX_IRQ_MASK, 2'b00};
	localparam logic [7:0] A_CRC = {adcsr_pkg::IDX_CRC, 2'b00};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, irq, link_sclk, link_crc_fail;
	logic link_lock = 1'b0, resync_pulse = 1'b0;
	logic [3:0] new_sample = 4'h0;
	logic [15:0] register_map_checksum_value = 16'h0000;
	logic [3:0] pstrb = 4'hF;
	int fail_count = 0;
	int n_tests = 0;

	// device under test; clock enable is held on
	adcsr_regs i_adcsr_regs (
		.clk(clk), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link_lock(link_lock),
		.resync_pulse(resync_pulse), .new_sample(new_sample),
		.register_map_checksum_value(register_map_checksum_value), .link_sclk(link_sclk),
		.link_crc_fail(link_crc_fail), .irq(irq)
	);
	adcsr_link_model i_adcsr_link_model (
		.link_sclk(link_sclk),
		.link_crc_fail(link_crc_fail)
	);

	// 100 MHz clock
	always #5 clk = ~clk;

	// compare and count; unknowns never match
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one transfer; request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// ends when pready is seen high; if it never rises, only the watchdog ends this wait
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// let n edges land, then sample at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_reset;
		apb(1'b0, A_ID, 16'h0000);
		chk(rd[15:12], adcsr_pkg::ID_UPPER_DEFAULT);
		chk(rd[11:8], 4'h4);
		chk({rd[31:8], 8'h00}, {16'h0000, adcsr_pkg::ID_UPPER_DEFAULT, 12'h400});
		apb(1'b0, A_ST, 16'h0000);
		chk(rd, 32'h0000_0500);
		chk(rd[15], 1'b0);
		chk(rd[11], 1'b0);
		chk(rd[10], 1'b1);
		chk(rd[9:8], 2'h1);
		$display("test reset values done");
	endtask

	task automatic t_readonly;
		apb(1'b1, A_ID, 16'hFFFF);
		chk(er, 1'b0);
		apb(1'b1, A_ST, 16'hFFFF);
		apb(1'b0, A_ID, 16'h0000);
		chk(rd[15:8], {adcsr_pkg::ID_UPPER_DEFAULT, 4'h4});
		apb(1'b0, A_ST, 16'h0000);
		chk(rd, 32'h0000_0500);
		apb(1'b0, 8'hC0, 16'h0000);
		chk(er, 1'b1);
		apb(1'b1, 8'h09, 16'hFFFF);
		chk(er, 1'b1);
		$display("test read-only and unmapped done");
	endtask

	// reset value, then all ones written; bits with no storage read back 0
	task automatic ch3_word(input logic [5:0] i, input logic [15:0] rv, input logic [15:0] ev);
		apb(1'b0, {i, 2'b00}, 16'h0000);
		chk(rd, {16'h0000, rv});
		apb(1'b1, {i, 2'b00}, 16'hFFFF);
		chk(er, 1'b0);
		apb(1'b0, {i, 2'b00}, 16'h0000);
		chk(rd, {16'h0000, ev});
	endtask

	task automatic t_chan3;
		ch3_word(adcsr_pkg::IDX_CH3_PHASE, 16'h0000, 16'hFFFF);
		ch3_word(adcsr_pkg::IDX_CH3_OCAL_HI, 16'h0000, 16'hFFFF);
		ch3_word(adcsr_pkg::IDX_CH3_OCAL_LO, 16'h0000, 16'hFF00);
		ch3_word(adcsr_pkg::IDX_CH3_GCAL_HI, 16'h8000, 16'hFFFF);
		ch3_word(adcsr_pkg::IDX_CH3_GCAL_LO, 16'h0000, 16'hFF00);
		ch3_word(adcsr_pkg::IDX_RSVD, 16'h0000, 16'h0000);
		$display("test channel 3 words done");
	endtask

	task automatic t_flags;
		link_lock <= 1'b1;
		new_sample <= 4'hA;
		@(posedge clk);
		resync_pulse <= 1'b1;
		@(posedge clk);
		resync_pulse <= 1'b0;
		cyc(2);
		chk(irq, 1'b0);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[15:14], 2'h3);
		chk(rd[3:0], 4'hA);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[14], 1'b0);
		apb(1'b1, A_MASK, 16'h0001);
		cyc(2);
		chk(irq, 1'b1);
		apb(1'b0, A_IRQ, 16'h0000);
		chk(rd[3:0], 4'h9);
		cyc(2);
		chk(irq, 1'b0);
		$display("test status flags and interrupt done");
	endtask

	task automatic t_mode;
		// every checksum kind and word length, reset flag kept at 1
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, A_MODE, {4'h0, i[2], 1'b1, i[1:0], 8'h10});
			apb(1'b0, A_ST, 16'h0000);
			chk(rd[11:8], {i[2], 1'b1, i[1:0]});
		end
		// a write that skips the upper lane leaves the reset flag alone
		pstrb <= 4'h1;
		apb(1'b1, A_MODE, 16'h0000);
		pstrb <= 4'hF;
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[11:8], 4'hF);
		apb(1'b1, A_MODE, 16'h0110);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[10], 1'b0);
		apb(1'b1, A_MODE, 16'h0510);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[10], 1'b0);
		$display("test mode mirror done");
	endtask

	task automatic t_crc;
		register_map_checksum_value <= 16'h1234;
		cyc(2);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[13], 1'b0);
		apb(1'b1, A_MODE, 16'h2110);
		register_map_checksum_value <= 16'h4321;
		cyc(2);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[13], 1'b1);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[13], 1'b0);
		apb(1'b0, A_CRC, 16'h0000);
		chk(rd[15:0], 16'h4321);
		i_adcsr_link_model.frame(1'b0);
		cyc(10);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[12], 1'b0);
		i_adcsr_link_model.frame(1'b1);
		cyc(10);
		apb(1'b0, A_ST, 16'h0000);
		chk(rd[12], 1'b1);
		$display("test checksum flags done");
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// main sequence after five reset cycles
	initial
	begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_reset;
		t_readonly;
		t_chan3;
		t_flags;
		t_mode;
		t_crc;
		stop_test;
	end

	// watchdog well beyond the expected few hundred cycles
	initial
	begin
		#200000;
		fail_count++;
		stop_test;
	end
endmodule
